// >>> pst_table_access.sv
`timescale 1ns/100ps
module pst_table_access
   import pst_pkg::*;
#(
   parameter bit LARGE_PART = 1'b1
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire pst_req_s    core_req,
   input  wire logic [15:0] page_wdata,
   input  wire logic        page_we,
   output pst_rsp_s         core_rsp,
   output logic [15:0]      page_rdata,
   output logic [23:0]      mem_addr,
   output logic             mem_rd,
   input  wire logic [23:0] mem_rdata,
   output logic             latch_we,
   output logic [1:0]       latch_be,
   output logic [23:0]      latch_wdata,
   output logic [95:0]      cfg_regs,
   output logic             cfg_valid
);
   // ----------------------------------------
   // Page register and address forming
   // ----------------------------------------
   logic [15:0] table_page_register_r;
   pst_state_e  state_r;
   pst_state_e  state_nxt;
   logic [1:0]  cfg_idx_r;
   logic        cfg_space;
   logic        cur_high_r;
   logic        cur_byte_r;
   logic        cur_sel_r;
   logic [23:0] cfg_base;
   logic [23:0] req_addr;
   logic        rd_go;
   logic        wr_go;

   assign cfg_base  = LARGE_PART ? PST_CFG_BASE_LARGE : PST_CFG_BASE_SMALL;
   assign cfg_space = table_page_register_r[PST_PAGE_CFG_BIT];
   // Word address ignores offset bit 0, which is the byte select
   assign req_addr  = {table_page_register_r[7:0], core_req.offset[15:1], 1'b0};
   // Requests wait for the copy; the sequencer is busy until then
   assign rd_go = core_req.valid && !core_req.write && state_r == PST_ST_IDLE;
   assign wr_go = core_req.valid && core_req.write && state_r == PST_ST_IDLE
                  && !cfg_space;

   // ----------------------------------------
   // Read data steering
   // ----------------------------------------
   logic [15:0] lo_data;
   logic [15:0] hi_data;
   logic [15:0] rd_sel;
   assign lo_data = cur_byte_r ? {8'h00, cur_sel_r ? mem_rdata[15:8] : mem_rdata[7:0]}
                               : mem_rdata[15:0];
   assign hi_data = (cur_byte_r && cur_sel_r) ? PST_PHANTOM_DATA
                                              : {8'h00, mem_rdata[23:16]};
   assign rd_sel  = cur_high_r ? hi_data : lo_data;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         PST_ST_LOAD: state_nxt = (cfg_idx_r == 2'(PST_CFG_WORDS - 1)) ? PST_ST_WAIT
                                                                        : PST_ST_LOAD;
         PST_ST_WAIT: state_nxt = PST_ST_IDLE;
         default:     state_nxt = rd_go ? PST_ST_WAIT : PST_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_r               <= PST_ST_LOAD;
         cfg_idx_r             <= 2'h0;
         table_page_register_r <= PST_PAGE_RST;
      end else begin
         state_r <= state_nxt;
         if (state_r == PST_ST_LOAD)
            cfg_idx_r <= cfg_idx_r + 2'h1;
         if (page_we)
            table_page_register_r <= page_wdata;
      end
   end

   // ----------------------------------------
   // Request capture
   // ----------------------------------------
   // Only reads need their shape kept; writes finish in one cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         cur_high_r <= 1'b0;
         cur_byte_r <= 1'b0;
         cur_sel_r  <= 1'b0;
      end else if (rd_go) begin
         cur_high_r <= core_req.high;
         cur_byte_r <= core_req.byte_mode;
         cur_sel_r  <= core_req.offset[0];
      end
   end

   // ----------------------------------------
   // Memory port
   // ----------------------------------------
   logic        load_capture;
   logic        load_done;
   logic [1:0]  load_slot_r;
   logic        mem_rd_nxt;
   logic [23:0] load_addr;
   logic [23:0] mem_addr_nxt;

   // Flash data stands in the cycle mem_rd is high, one cycle after the address is chosen, so the copy lags one word
   assign load_capture = (state_r == PST_ST_WAIT && !cfg_valid)
                         || (state_r == PST_ST_LOAD && cfg_idx_r != 2'h0);
   assign load_done    = state_r == PST_ST_WAIT
                         && load_slot_r == 2'(PST_CFG_WORDS - 1);
   assign load_addr    = cfg_base + {21'h0, cfg_idx_r, 1'b0};
   assign mem_rd_nxt   = state_r == PST_ST_LOAD || rd_go;
   // Writes steer the address too, so the latch knows where it lands
   assign mem_addr_nxt = (state_r == PST_ST_LOAD) ? load_addr
                       : (rd_go || wr_go)          ? req_addr
                       :                             mem_addr;

   always_ff @(posedge clk) begin
      if (srst) begin
         mem_addr    <= 24'h000000;
         mem_rd      <= 1'b0;
         load_slot_r <= 2'h0;
      end else begin
         mem_addr <= mem_addr_nxt;
         mem_rd   <= mem_rd_nxt;
         if (state_r == PST_ST_LOAD)
            load_slot_r <= cfg_idx_r;
      end
   end

   // ----------------------------------------
   // Configuration copy
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_regs  <= '0;
         cfg_valid <= 1'b0;
      end else begin
         // Straight copy, nothing scattered: each 24-bit word lands whole in its own register slot
         if (load_capture)
            cfg_regs[load_slot_r*24 +: 24] <= mem_rdata;
         if (load_done)
            cfg_valid <= 1'b1;
      end
   end

   // ----------------------------------------
   // Write latch
   // ----------------------------------------
   logic [1:0]  wr_be;
   logic [23:0] wr_data;
   logic [23:0] lo_byte_data;

   // Low byte writes keep be 01; the select only moves the byte lane
   assign lo_byte_data = core_req.offset[0] ? {8'h00, core_req.wdata[7:0], 8'h00}
                                            : {16'h0000, core_req.wdata[7:0]};
   // High writes ignore byte mode: only one real byte lives up there
   assign wr_be        = core_req.high ? 2'b10 : 2'b01;
   assign wr_data      = core_req.high      ? {core_req.wdata[7:0], 16'h0000}
                       : core_req.byte_mode ? lo_byte_data
                       :                      {8'h00, core_req.wdata};

   always_ff @(posedge clk) begin
      if (srst) begin
         latch_we    <= 1'b0;
         latch_be    <= 2'h0;
         latch_wdata <= 24'h000000;
      end else begin
         latch_we <= wr_go;
         if (wr_go) begin
            latch_be    <= wr_be;
            latch_wdata <= wr_data;
         end
      end
   end

   // ----------------------------------------
   // Responses
   // ----------------------------------------
   logic        rd_done;
   logic        wr_done;

   assign rd_done = state_r == PST_ST_WAIT && cfg_valid;
   // Refused config-space writes still complete; the latch and mem_addr stay quiet
   assign wr_done = core_req.valid && core_req.write && state_r == PST_ST_IDLE;

   always_ff @(posedge clk) begin
      if (srst) begin
         core_rsp   <= '0;
         page_rdata <= PST_PAGE_RST;
      end else begin
         core_rsp.done  <= rd_done || wr_done;
         // Zero outside the done cycle so a stale word never leaks
         core_rsp.rdata <= rd_done ? rd_sel : 16'h0000;
         page_rdata     <= page_we ? page_wdata : table_page_register_r;
      end
   end
endmodule

// >>> pst_pkg.sv
package pst_pkg;
   // ----------------------------------------
   // Address map
   // ----------------------------------------
   localparam logic [23:0] PST_CFG_BASE_SMALL = 24'h0157f8;
   localparam logic [23:0] PST_CFG_LAST_SMALL = 24'h0157fe;
   localparam logic [23:0] PST_CFG_BASE_LARGE = 24'h02abf8;
   localparam logic [23:0] PST_CFG_LAST_LARGE = 24'h02abfe;
   localparam int          PST_CFG_WORDS      = 4;
   localparam int          PST_PAGE_CFG_BIT   = 7;
   localparam logic [15:0] PST_PHANTOM_DATA   = 16'h0000;
   localparam logic [15:0] PST_PAGE_RST       = 16'h0000;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      PST_ST_IDLE = 2'b00,
      PST_ST_WAIT = 2'b01,
      PST_ST_LOAD = 2'b11
   } pst_state_e;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        high;
      logic        byte_mode;
      logic [15:0] offset;
      logic [15:0] wdata;
   } pst_req_s;

   typedef struct packed {
      logic        done;
      logic [15:0] rdata;
   } pst_rsp_s;
endpackage

// >>> pst_props.sv
`timescale 1ns/100ps
module pst_props
   import pst_pkg::*;
#(parameter bit LARGE_PART = 1'b1) (
   input wire logic        clk,
   input wire logic        srst,
   input wire pst_req_s    core_req,
   input wire pst_rsp_s    core_rsp,
   input wire logic [15:0] page_rdata,
   input wire logic [23:0] mem_addr,
   input wire logic        mem_rd,
   input wire logic        latch_we,
   input wire logic        cfg_valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic [23:0] base;
   logic        idle, rd_t, wr_t;
   assign base = LARGE_PART ? PST_CFG_BASE_LARGE : PST_CFG_BASE_SMALL;
   // Conservative: a request beside a done pulse is not counted
   assign idle = core_req.valid & cfg_valid & ~mem_rd & ~core_rsp.done;
   assign rd_t = idle & ~core_req.write;
   assign wr_t = idle & core_req.write;
   chk_read_fetch:
      assert property (rd_t |=> mem_rd && mem_addr[15:1] == $past(core_req.offset[15:1]))
         else $error("read fetch wrong");
   chk_read_answer:
      assert property (rd_t |-> ##2 core_rsp.done) else $error("read not answered");
   chk_write_latch:
      assert property (wr_t && !page_rdata[7] |=> latch_we && core_rsp.done)
         else $error("write not latched");
   chk_cfg_write_block:
      assert property (wr_t && page_rdata[7] |=> !latch_we && core_rsp.done)
         else $error("config write latched");
   chk_rdata_idle:
      assert property (!core_rsp.done |-> core_rsp.rdata == 16'h0000) else $error("stray rdata");
   chk_phantom_zero:
      assert property ($past(rd_t, 2) && $past(core_req.high, 2) |-> core_rsp.rdata[15:8] == 8'h00)
         else $error("phantom byte set");
   chk_cfg_range:
      assert property (mem_rd && !cfg_valid |-> mem_addr >= base && mem_addr <= base + 24'h000006)
         else $error("config address out of range");
   chk_cfg_step:
      assert property (mem_rd && $past(mem_rd) && !cfg_valid |-> mem_addr == $past(mem_addr) + 24'h000002)
         else $error("config step wrong");
endmodule

// >>> pst_flash_model.sv
`timescale 1ns/100ps
module pst_flash_model (
   input  wire logic        clk,
   input  wire logic        mem_rd,
   input  wire logic [23:0] mem_addr,
   output logic      [23:0] mem_rdata
);
   logic [23:0] word, hold_r;
   assign word = {mem_addr[8:1] ^ 8'h96, mem_addr[16:1] ^ 16'h3c5a};
   // Held one cycle past the read, then churns so stale data shows
   assign mem_rdata = mem_rd ? word : hold_r;
   always_ff @(posedge clk) hold_r <= mem_rd ? word : ~hold_r;
endmodule

// >>> pst_tb.sv
`timescale 1ns/100ps
module tb;
   import pst_pkg::*;
   logic clk, srst, page_we, mem_rd, latch_we, cfg_valid;
   logic [15:0] page_wdata, page_rdata;
   logic [23:0] mem_addr, mem_rdata, latch_wdata;
   logic [1:0]  latch_be;
   logic [95:0] cfg_regs;
   pst_req_s    core_req;
   pst_rsp_s    core_rsp;
   int          failures = 0, comparisons = 0, cycles = 0;
   pst_table_access #(.LARGE_PART(1'b1)) i_dut (.clk(clk), .srst(srst), .core_req(core_req),
      .page_wdata(page_wdata), .page_we(page_we), .core_rsp(core_rsp), .page_rdata(page_rdata),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .latch_we(latch_we),
      .latch_be(latch_be), .latch_wdata(latch_wdata), .cfg_regs(cfg_regs), .cfg_valid(cfg_valid));
   pst_flash_model i_mem (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
   function automatic logic [23:0] pat(logic [23:0] a);
      return {a[8:1] ^ 8'h96, a[16:1] ^ 16'h3c5a};
   endfunction
   task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         wrap_up;
      end
   end
   task automatic boot;
      int n;
      srst = 1;
      repeat (3) @(negedge clk);
      srst = 0;
      for (n = 0; n < 50 && cfg_valid !== 1'b1; n++) @(negedge clk);
      for (int i = 0; i < 4; i++)
         chk("cfg", pat(PST_CFG_BASE_LARGE + 24'(2 * i)), cfg_regs[i*24 +: 24]);
   endtask
   task automatic set_page(logic [15:0] v);
      page_we = 1;
      page_wdata = v;
      @(negedge clk);
      page_we = 0;
      chk("page", {8'h00, v}, {8'h00, page_rdata});
   endtask
   task automatic rd(logic hi, logic bm, logic [15:0] off);
      logic [23:0] p;
      logic [15:0] e;
      p = pat({page_rdata[7:0], off});
      e = hi ? ((bm && off[0]) ? 16'h0000 : {8'h00, p[23:16]})
             : (!bm ? p[15:0] : {8'h00, off[0] ? p[15:8] : p[7:0]});
      core_req = '{1'b1, 1'b0, hi, bm, off, 16'h0000};
      @(negedge clk);
      core_req.valid = 0;
      @(negedge clk);
      chk("rd done", 24'h000001, {23'h0, core_rsp.done});
      chk("rd data", {8'h00, e}, {8'h00, core_rsp.rdata});
   endtask
   task automatic wr(logic hi, logic [15:0] off, logic [15:0] d, logic en);
      logic [23:0] m;
      m = hi ? 24'hff0000 : 24'h00ffff;
      core_req = '{1'b1, 1'b1, hi, 1'b0, off, d};
      @(negedge clk);
      core_req.valid = 0;
      chk("wr done", 24'h000001, {23'h0, core_rsp.done});
      chk("latch we", {23'h0, en}, {23'h0, latch_we});
      if (en) chk("latch be", {22'h0, hi ? 2'b10 : 2'b01}, {22'h0, latch_be});
      if (en) chk("latch", hi ? {d[7:0], 16'h0} : {8'h0, d}, latch_wdata & m);
      @(negedge clk);
   endtask
   task automatic t_reads;
      set_page(16'h0001);
      for (int k = 0; k < 8; k++) rd(k[2], k[1], 16'h1234 | 16'(k[0]));
      set_page(16'h0080);
      rd(1'b1, 1'b0, 16'h2bfa);
   endtask
   task automatic t_writes;
      set_page(16'h0002);
      wr(1'b0, 16'h4566, 16'hbeef, 1'b1);
      wr(1'b1, 16'h4566, 16'h00c3, 1'b1);
      set_page(16'h0080);
      wr(1'b0, 16'h0010, 16'h1234, 1'b0);
   endtask
   initial begin
      srst = 1;
      page_we = 0;
      page_wdata = 16'h0000;
      core_req = '0;
      // Second pass repeats the config copy after a mid-run reset
      repeat (2) begin
         boot;
         t_reads;
         t_writes;
      end
      wrap_up;
   end
endmodule
bind pst_table_access pst_props #(.LARGE_PART(LARGE_PART)) i_props (.clk(clk), .srst(srst),
   .core_req(core_req), .core_rsp(core_rsp), .page_rdata(page_rdata), .mem_addr(mem_addr),
   .mem_rd(mem_rd), .latch_we(latch_we), .cfg_valid(cfg_valid));
